/* File: hdl/ext_bus_consts.vh */
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

// Register byte offsets.
`define REG_CTRL 5'h00
`define REG_ACCESS_STATE 5'h04
`define REG_BUS_WIDTH 5'h08
`define REG_DRAM_CFG 5'h0C
`define REG_STATUS 5'h10

// Control register field positions.
`define CTL_IDLE_AREA 0
`define CTL_IDLE_WAR 1
`define CTL_BROM_EN 2
`define CTL_BURST_LEN 3
`define CTL_BURST_WORDS 4
`define CTL_WBUF_EN 5
`define CTL_ACK_TIMING 6
`define CTL_RAS_HOLD 7
`define CTL_DRAM_BURST 8
`define CTL_WAIT_PIN 9
`define CTL_ADVANCED 10
`define CTL_WIDTH 11

// Reset values.
`define CTL_RESET 11'h403
`define ACCESS_STATE_RESET 8'hFF
`define BUS_WIDTH_RESET 8'hFF
`define DRAM_AREAS_RESET 8'h00
`define PROG_WAIT_RESET 2'h3

// Address slicing and burst limits.
`define AREA_MSB 23
`define AREA_LSB 21
`define ROW_LSB 9
`define BURST_LIMIT_4 3'h3
`define BURST_LIMIT_8 3'h7
`define BLOCK_MASK_4 24'hFFFFF8
`define BLOCK_MASK_8 24'hFFFFF0

`endif

/* File: hdl/bit_sync.v */
`timescale 1ns/1ns
// Two-flop synchroniser; the first flop feeds only the second.
module bit_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire clk,
	input wire arst_n,
	input wire d,
	output wire q
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule

/* File: hdl/idle_check.v */
`timescale 1ns/1ns
// Decides whether an idle state precedes the cycle being started.
module idle_check (
	input wire prev_read,
	input wire [2:0] prev_area,
	input wire [2:0] cur_area,
	input wire cur_write,
	input wire idle_between_area_reads,
	input wire idle_write_after_read,
	input wire advanced_mode,
	input wire cur_dram,
	input wire cur_dram_hold_burst,
	output wire need_idle
);
	wire area_case;
	wire war_case;
	wire settings_apply;

	assign area_case = idle_between_area_reads & advanced_mode & !cur_write &
		(prev_area != cur_area);
	assign war_case = idle_write_after_read & cur_write;
	// A DRAM cycle brings its own precharge or is a page hit; only a held-row burst takes idle settings.
	assign settings_apply = !cur_dram | cur_dram_hold_burst;
	assign need_idle = prev_read & settings_apply & (area_case | war_case);
endmodule

/* File: hdl/ext_bus_burst_idle_ctrl.v */
`timescale 1ns/1ns
// Functional notes
// - With late ack timing, DRAM page bursts depend on address only, not master.
// - Late ack timing drives the DMA ack low from column state one.
// - Early ack timing forces full DRAM access for DMA single-address transfers.
// - Early ack timing drives the DMA ack low from the row state.
// - Early ack timing still allows page bursts for other DRAM accesses.
// - Area 0 burst ROM mode bursts only on CPU instruction fetches.
// - Burst limit is four words, or eight when word count select is set.
// - Initial burst ROM cycle length follows area 0 access state bit; waits need it.
// - Initial burst ROM cycle takes program and pin waits like basic cycles.
// - Burst ROM burst cycles last one or two states.
// - No wait states ever enter a burst ROM burst cycle.
// - Burst ROM area 0 is always 16-bit, ignoring its width bit.
// - Advanced mode reads of differing areas get one idle state first.
// - A write after a read gets one idle state first.
// - Both idle insertions are enabled after reset.
// - DRAM accesses other than held-row bursts ignore idle settings; full ones take only precharge, page hits none.
// - Held-row DRAM bursts honour both idle settings.
// - Idle state drives next address, floats data, holds strobes and ack high.
// - Idle state holds selects high, except a held DRAM row stays low.
// - Write buffer lets external writes overlap internal reads.
// - Overlap starts only from the second state of the external write.
// - Full DRAM access is precharge, row, column one, column two.
// - Row hold mode keeps the row strobe low across other spaces.
`include "ext_bus_consts.vh"
module ext_bus_burst_idle_ctrl (
	input wire core_clk,
	input wire rst_n,
	input wire [4:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire req_valid,
	output wire req_ready,
	input wire [23:0] req_addr,
	input wire req_write,
	input wire req_byte,
	input wire [15:0] req_wdata,
	input wire req_fetch,
	input wire req_dma_sa,
	output reg resp_valid,
	output reg [15:0] resp_rdata,
	input wire int_req,
	output wire int_grant,
	output wire [23:0] ext_addr,
	output wire [15:0] ext_data_out,
	output wire ext_data_oe,
	input wire [15:0] ext_data_in,
	output wire [7:0] chip_select_n,
	output wire column_strobe_n,
	output wire address_strobe_n,
	output wire read_strobe_n,
	output wire upper_write_strobe_n,
	output wire lower_write_strobe_n,
	output wire dma_transfer_ack_n,
	input wire wait_n
);
	localparam S_READY = 4'h0;
	localparam S_IDLE = 4'h1;
	localparam S_T1 = 4'h2;
	localparam S_T2 = 4'h3;
	localparam S_TW = 4'h4;
	localparam S_T3 = 4'h5;
	localparam S_TP = 4'h6;
	localparam S_TR = 4'h7;
	localparam S_TC1 = 4'h8;
	localparam S_DTW = 4'h9;
	localparam S_TC2 = 4'hA;
	localparam S_B1 = 4'hB;
	localparam S_B2 = 4'hC;

	function [2:0] area_of;
		input [23:0] a;
		begin
			area_of = a[`AREA_MSB:`AREA_LSB];
		end
	endfunction

	wire rst_sync_n;
	wire wait_s_n;

	bit_sync #(.RESET_VAL(1'b0)) u_rst_sync (
		.clk(core_clk),
		.arst_n(rst_n),
		.d(1'b1),
		.q(rst_sync_n)
	);

	bit_sync #(.RESET_VAL(1'b1)) u_wait_sync (
		.clk(core_clk),
		.arst_n(rst_sync_n),
		.d(wait_n),
		.q(wait_s_n)
	);

	reg [`CTL_WIDTH-1:0] ctl_q;
	reg [7:0] access_state_ctrl_q;
	reg [7:0] bus_width_ctrl_q;
	reg [7:0] dram_areas_q;
	reg [1:0] prog_wait_q;

	wire idle_between_area_reads = ctl_q[`CTL_IDLE_AREA];
	wire idle_write_after_read = ctl_q[`CTL_IDLE_WAR];
	wire area0_burst_rom_enable = ctl_q[`CTL_BROM_EN];
	wire burst_cycle_length_sel = ctl_q[`CTL_BURST_LEN];
	wire burst_word_count_sel = ctl_q[`CTL_BURST_WORDS];
	wire write_buffer_enable = ctl_q[`CTL_WBUF_EN];
	wire ack_timing_select = ctl_q[`CTL_ACK_TIMING];
	wire ras_hold_mode_sel = ctl_q[`CTL_RAS_HOLD];
	wire dram_burst_enable = ctl_q[`CTL_DRAM_BURST];
	wire wait_pin_enable = ctl_q[`CTL_WAIT_PIN];
	wire advanced_mode = ctl_q[`CTL_ADVANCED];

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [3:0] go_q;
	reg first_q;
	reg [1:0] wcnt_q;
	reg [23:0] cur_addr_q;
	reg [15:0] cur_wdata_q;
	reg cur_write_q;
	reg cur_byte_q;
	reg cur_dma_q;
	reg cur_dram_q;
	reg cur_narrow_q;
	reg cur_slow_q;
	reg last_read_q;
	reg [2:0] last_area_q;
	reg row_open_q;
	reg [2:0] open_area_q;
	reg [23:`ROW_LSB] open_row_q;
	reg brom_valid_q;
	reg [23:0] brom_addr_q;
	reg [2:0] brom_cnt_q;

	// Decisions on the request being offered.
	wire [2:0] req_area = area_of(req_addr);
	wire req_dram = dram_areas_q[req_area];
	wire req_brom_space = area0_burst_rom_enable & (req_area == 3'h0);
	wire dma_forces_full = req_dma_sa & !ack_timing_select;
	wire page_hit = dram_burst_enable & row_open_q & (open_area_q == req_area) &
		(open_row_q == req_addr[23:`ROW_LSB]) & !dma_forces_full;
	wire hold_burst = page_hit & ras_hold_mode_sel;
	wire [23:0] block_mask = burst_word_count_sel ? `BLOCK_MASK_8 : `BLOCK_MASK_4;
	wire [2:0] burst_limit = burst_word_count_sel ? `BURST_LIMIT_8 : `BURST_LIMIT_4;
	wire same_block = ((req_addr ^ brom_addr_q) & block_mask) == 24'h000000;
	wire brom_hit = req_brom_space & req_fetch & brom_valid_q & same_block &
		(brom_cnt_q < burst_limit);
	wire need_idle;
	wire take = req_valid & (state_q == S_READY);
	wire [3:0] first_state = req_dram ? (page_hit ? S_TC1 : S_TP) :
		(brom_hit ? S_B1 : S_T1);

	idle_check u_idle (
		.prev_read(last_read_q),
		.prev_area(last_area_q),
		.cur_area(req_area),
		.cur_write(req_write),
		.idle_between_area_reads(idle_between_area_reads),
		.idle_write_after_read(idle_write_after_read),
		.advanced_mode(advanced_mode),
		.cur_dram(req_dram),
		.cur_dram_hold_burst(hold_burst),
		.need_idle(need_idle)
	);

	assign req_ready = (state_q == S_READY);

	// Waits only where the access state bit allows them; never in burst ROM burst cycles.
	wire want_wait = cur_slow_q & ((wcnt_q < prog_wait_q) |
		(wait_pin_enable & !wait_s_n));
	wire last_state = (state_q == S_TC2) | (state_q == S_T3) |
		((state_q == S_T2) & !cur_slow_q) | (state_q == S_B2) |
		((state_q == S_B1) & !burst_cycle_length_sel);

	always @* begin
		state_d = state_q;
		case (state_q)
			S_READY: begin
				if (take) begin
					state_d = need_idle ? S_IDLE : first_state;
				end
			end
			S_IDLE: state_d = go_q;
			S_T1: state_d = S_T2;
			S_T2: begin
				if (cur_slow_q) begin
					state_d = want_wait ? S_TW : S_T3;
				end else begin
					state_d = S_READY;
				end
			end
			S_TW: state_d = want_wait ? S_TW : S_T3;
			S_T3: state_d = S_READY;
			S_TP: state_d = S_TR;
			S_TR: state_d = S_TC1;
			S_TC1: state_d = want_wait ? S_DTW : S_TC2;
			S_DTW: state_d = want_wait ? S_DTW : S_TC2;
			S_TC2: state_d = S_READY;
			S_B1: state_d = burst_cycle_length_sel ? S_B2 : S_READY;
			S_B2: state_d = S_READY;
			default: state_d = S_READY;
		endcase
	end

	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q <= S_READY;
			go_q <= S_READY;
			first_q <= 1'b0;
			wcnt_q <= 2'h0;
			cur_addr_q <= 24'h000000;
			cur_wdata_q <= 16'h0000;
			cur_write_q <= 1'b0;
			cur_byte_q <= 1'b0;
			cur_dma_q <= 1'b0;
			cur_dram_q <= 1'b0;
			cur_narrow_q <= 1'b0;
			cur_slow_q <= 1'b0;
			last_read_q <= 1'b0;
			last_area_q <= 3'h0;
			row_open_q <= 1'b0;
			open_area_q <= 3'h0;
			open_row_q <= {(24-`ROW_LSB){1'b0}};
			brom_valid_q <= 1'b0;
			brom_addr_q <= 24'h000000;
			brom_cnt_q <= 3'h0;
			resp_valid <= 1'b0;
			resp_rdata <= 16'h0000;
		end else begin
			state_q <= state_d;
			resp_valid <= 1'b0;
			first_q <= (state_d != state_q) & ((state_q == S_READY) |
				(state_q == S_IDLE)) & (state_d != S_IDLE);
			if ((state_q == S_TW) | (state_q == S_DTW) |
				((state_q == S_T2) & (state_d == S_TW)) |
				((state_q == S_TC1) & (state_d == S_DTW))) begin
				wcnt_q <= (wcnt_q == 2'h3) ? wcnt_q : wcnt_q + 2'h1;
			end else if (state_q == S_READY) begin
				wcnt_q <= 2'h0;
			end
			if (take) begin
				go_q <= first_state;
				cur_addr_q <= req_addr;
				cur_wdata_q <= req_wdata;
				cur_write_q <= req_write;
				cur_byte_q <= req_byte;
				cur_dma_q <= req_dma_sa;
				cur_dram_q <= req_dram;
				cur_narrow_q <= bus_width_ctrl_q[req_area] & !req_brom_space;
				cur_slow_q <= access_state_ctrl_q[req_area];
				if (req_dram) begin
					if (!page_hit) begin
						row_open_q <= 1'b0;
					end
				end else if (!ras_hold_mode_sel) begin
					row_open_q <= 1'b0;
				end
				if (req_brom_space & req_fetch) begin
					brom_valid_q <= 1'b1;
					brom_addr_q <= req_addr;
					brom_cnt_q <= brom_hit ? brom_cnt_q + 3'h1 : 3'h0;
				end else begin
					brom_valid_q <= 1'b0;
				end
			end
			if (last_state) begin
				resp_valid <= 1'b1;
				resp_rdata <= cur_write_q ? 16'h0000 :
					(cur_narrow_q ? {8'h00, ext_data_in[15:8]} : ext_data_in);
				last_read_q <= !cur_write_q;
				last_area_q <= area_of(cur_addr_q);
				if (cur_dram_q & dram_burst_enable) begin
					row_open_q <= 1'b1;
					open_area_q <= area_of(cur_addr_q);
					open_row_q <= cur_addr_q[23:`ROW_LSB];
				end
			end
		end
	end

	// Pin decode.
	wire in_basic = (state_q == S_T1) | (state_q == S_T2) | (state_q == S_TW) |
		(state_q == S_T3);
	wire in_burst = (state_q == S_B1) | (state_q == S_B2);
	wire in_col = (state_q == S_TC1) | (state_q == S_DTW) | (state_q == S_TC2);
	wire in_row_act = (state_q == S_TR) | in_col;
	wire in_idle = (state_q == S_IDLE);
	wire wr_phase = (in_basic & (state_q != S_T1)) | in_col;
	wire [2:0] cur_area = area_of(cur_addr_q);
	wire ack_dram = ack_timing_select ? in_col : in_row_act;

	// Row and column multiplexed onto the low address lines for DRAM.
	assign ext_addr = (cur_dram_q & ((state_q == S_TP) | (state_q == S_TR))) ?
		{{`ROW_LSB{1'b0}}, cur_addr_q[23:`ROW_LSB]} : cur_addr_q;
	assign ext_data_out = cur_narrow_q ? {cur_wdata_q[7:0], 8'h00} : cur_wdata_q;
	assign ext_data_oe = cur_write_q & (in_basic | in_col);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_cs
			wire area_hit = (cur_area == gi);
			wire basic_sel = area_hit & !cur_dram_q & (in_basic | in_burst);
			wire dram_sel = area_hit & cur_dram_q & in_row_act;
			// A held row keeps its strobe low through idle and other spaces.
			wire held_sel = row_open_q & (open_area_q == gi) &
				(state_q != S_TP);
			assign chip_select_n[gi] = !(basic_sel | dram_sel | held_sel);
		end
	endgenerate

	assign address_strobe_n = !in_basic;
	assign read_strobe_n = !(!cur_write_q & (in_basic | in_burst | in_col));
	assign column_strobe_n = !((state_q == S_DTW) | (state_q == S_TC2));
	assign upper_write_strobe_n = !(cur_write_q & wr_phase &
		(cur_narrow_q | !cur_byte_q | !cur_addr_q[0]));
	assign lower_write_strobe_n = !(cur_write_q & wr_phase & !cur_narrow_q &
		(!cur_byte_q | cur_addr_q[0]));
	assign dma_transfer_ack_n = !(cur_dma_q & !in_idle &
		(cur_dram_q ? ack_dram : in_basic));

	// The first state of a buffered write belongs to the write alone.
	assign int_grant = int_req & ((state_q == S_READY) | (write_buffer_enable &
		(cur_write_q | cur_dma_q) & (in_basic | in_row_act | in_burst) &
		!first_q));

	always @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctl_q <= `CTL_RESET;
			access_state_ctrl_q <= `ACCESS_STATE_RESET;
			bus_width_ctrl_q <= `BUS_WIDTH_RESET;
			dram_areas_q <= `DRAM_AREAS_RESET;
			prog_wait_q <= `PROG_WAIT_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`REG_CTRL: ctl_q <= reg_wdata[`CTL_WIDTH-1:0];
					`REG_ACCESS_STATE: access_state_ctrl_q <= reg_wdata[7:0];
					`REG_BUS_WIDTH: bus_width_ctrl_q <= reg_wdata[7:0];
					`REG_DRAM_CFG: begin
						dram_areas_q <= reg_wdata[7:0];
						prog_wait_q <= reg_wdata[9:8];
					end
					default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
					`REG_CTRL: reg_rdata <= {{(32-`CTL_WIDTH){1'b0}}, ctl_q};
					`REG_ACCESS_STATE: reg_rdata <= {24'h000000, access_state_ctrl_q};
					`REG_BUS_WIDTH: reg_rdata <= {24'h000000, bus_width_ctrl_q};
					`REG_DRAM_CFG: reg_rdata <= {22'h000000, prog_wait_q, dram_areas_q};
					`REG_STATUS: reg_rdata <= {16'h0000, brom_valid_q, brom_cnt_q,
						row_open_q, open_area_q, last_read_q, last_area_q, state_q};
					default: reg_rdata <= 32'h00000000;
				endcase
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end
	end
endmodule

/* File: bench/ext_bus_chk_asserts.sv */
`timescale 1ns/1ns
module ext_bus_chk (
	input wire core_clk,
	input wire rst_n,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire req_valid,
	input wire req_ready,
	input wire resp_valid,
	input wire int_req,
	input wire int_grant,
	input wire ext_data_oe,
	input wire [7:0] chip_select_n,
	input wire column_strobe_n,
	input wire address_strobe_n,
	input wire read_strobe_n,
	input wire upper_write_strobe_n,
	input wire lower_write_strobe_n,
	input wire dma_transfer_ack_n
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	wire cs_hi = &chip_select_n;
	a_rd_excl: assert property (
		!read_strobe_n |-> upper_write_strobe_n && lower_write_strobe_n && !ext_data_oe)
		else $error("read strobe beside write strobe or drive");
	a_wr_drive: assert property (
		!(upper_write_strobe_n && lower_write_strobe_n) |-> ext_data_oe)
		else $error("write strobe without data drive");
	a_idle_float: assert property (
		cs_hi |-> !ext_data_oe)
		else $error("data driven with no select");
	a_ack_sel: assert property (
		!dma_transfer_ack_n |-> !cs_hi)
		else $error("ack outside an access");
	a_cas_sel: assert property (
		!column_strobe_n |-> !cs_hi)
		else $error("column strobe without row strobe");
	a_as_sel: assert property (
		!address_strobe_n |-> !cs_hi)
		else $error("address strobe without select");
	a_grant_req: assert property (
		int_grant |-> int_req)
		else $error("grant without request");
	a_take_busy: assert property (
		req_valid && req_ready |=> !req_ready)
		else $error("ready right after take");
	a_resp_pulse: assert property (
		resp_valid |=> !resp_valid)
		else $error("response longer than one cycle");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data without read");
endmodule
bind ext_bus_burst_idle_ctrl ext_bus_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready),
	.resp_valid(resp_valid), .int_req(int_req), .int_grant(int_grant),
	.ext_data_oe(ext_data_oe), .chip_select_n(chip_select_n),
	.column_strobe_n(column_strobe_n), .address_strobe_n(address_strobe_n),
	.read_strobe_n(read_strobe_n),
	.upper_write_strobe_n(upper_write_strobe_n), .lower_write_strobe_n(lower_write_strobe_n),
	.dma_transfer_ack_n(dma_transfer_ack_n));

/* File: bench/ext_mem_model.sv */
`timescale 1ns/1ns
module ext_mem_model (
	input wire core_clk,
	input wire [23:0] ext_addr,
	input wire [15:0] ext_data_out,
	input wire read_strobe_n,
	input wire upper_write_strobe_n,
	input wire lower_write_strobe_n,
	input wire wait_hold,
	output wire [15:0] ext_data_in,
	output wire wait_n
);
	logic [15:0] mem [0:15];
	logic [15:0] last_q = 16'h0;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'hA500 + i;
		end
	end
	assign wait_n = !wait_hold;
	// A released bus shows the inverse of the last word, so stale data never matches.
	assign ext_data_in = !read_strobe_n ? mem[ext_addr[4:1]] : ~last_q;
	always @(posedge core_clk) begin
		if (!read_strobe_n) begin
			last_q <= mem[ext_addr[4:1]];
		end
		if (!upper_write_strobe_n || !lower_write_strobe_n) begin
			mem[ext_addr[4:1]] <= ext_data_out;
		end
	end
endmodule

/* File: bench/ext_bus_burst_idle_ctrl_test.sv */
`timescale 1ns/1ns
module ext_bus_burst_idle_ctrl_test;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, req_valid = 0, req_write = 0;
	logic req_fetch = 0, req_dma_sa = 0, int_req = 0, wait_hold = 0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [23:0] req_addr = 24'h0, ext_addr;
	logic [15:0] req_wdata = 16'h0, resp_rdata, ext_data_out, ext_data_in, rd;
	logic req_ready, resp_valid, int_grant, ext_data_oe, column_strobe_n, address_strobe_n;
	logic read_strobe_n, upper_write_strobe_n, lower_write_strobe_n, dma_transfer_ack_n, wait_n;
	logic [7:0] chip_select_n;
	logic [40:0] gm;
	logic [23:0] ea1;
	logic [7:0] cs1;
	logic [6:0] st1;
	int bad_count = 0, cmp_count = 0, t, ta, t1, t2, tb, tdr, tpg;
	ext_bus_burst_idle_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
		.req_write(req_write), .req_byte(1'b0), .req_wdata(req_wdata), .req_fetch(req_fetch),
		.req_dma_sa(req_dma_sa), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.int_req(int_req), .int_grant(int_grant), .ext_addr(ext_addr),
		.ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
		.chip_select_n(chip_select_n), .column_strobe_n(column_strobe_n),
		.address_strobe_n(address_strobe_n), .read_strobe_n(read_strobe_n),
		.upper_write_strobe_n(upper_write_strobe_n),
		.lower_write_strobe_n(lower_write_strobe_n),
		.dma_transfer_ack_n(dma_transfer_ack_n), .wait_n(wait_n));
	ext_mem_model mem (.core_clk(core_clk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
		.read_strobe_n(read_strobe_n), .upper_write_strobe_n(upper_write_strobe_n),
		.lower_write_strobe_n(lower_write_strobe_n), .wait_hold(wait_hold),
		.ext_data_in(ext_data_in), .wait_n(wait_n));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task tmo;
		bad_count++;
		$display("CHECK FAILED %0t wait ran out", $time);
		finish_test();
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, s, e);
		end
	endtask
	task rw(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rr(input logic [4:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask
	// Cycles from take to response land in t, first ack cycle in ta, grants per cycle in gm.
	// The pins of the first cycle after take land in ea1, cs1 and st1.
	task acc(input logic [23:0] a, input logic w, input logic f, input logic d);
		@(posedge core_clk);
		req_valid <= 1;
		req_addr <= a;
		req_write <= w;
		req_fetch <= f;
		req_dma_sa <= d;
		req_wdata <= a[15:0] ^ 16'h5A5A;
		t = 0;
		@(negedge core_clk);
		while (req_ready !== 1'b1) begin
			if (++t > 40) tmo();
			@(negedge core_clk);
		end
		@(posedge core_clk);
		req_valid <= 0;
		t = 0;
		ta = 0;
		gm = 0;
		do begin
			@(negedge core_clk);
			t++;
			gm[t] = int_grant;
			if (t == 1) begin
				ea1 = ext_addr;
				cs1 = chip_select_n;
				st1 = {address_strobe_n, read_strobe_n, upper_write_strobe_n,
					lower_write_strobe_n, column_strobe_n, dma_transfer_ack_n, ext_data_oe};
			end
			if (dma_transfer_ack_n === 1'b0 && ta == 0) ta = t;
			if (t > 40) tmo();
		end while (resp_valid !== 1'b1);
		rd = resp_rdata;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		repeat (3) @(posedge core_clk);
		rr(5'h00, 32'h403);
		rr(5'h04, 32'hFF);
		rr(5'h0C, 32'h300);
		rr(5'h10, 32'h0);
		rr(5'h14, 32'h0);
		rw(5'h08, 32'h01);
		rw(5'h04, 32'h01);
		for (int k = 0; k < 3; k++) begin
			rw(5'h00, k == 0 ? 32'h400 : (k == 1 ? 32'h403 : 32'h003));
			acc(24'h200000, 0, 0, 0);
			acc(24'h400000, 0, 0, 0);
			t1 = t;
			acc(24'h400000, 0, 0, 0);
			chk(t1 - t, k == 1);
			acc(24'h400012, 1, 0, 0);
			t1 = t;
			chk(st1, k != 0 ? 7'h7E : 7'h3F);
			chk(cs1, k != 0 ? 8'hFF : 8'hFB);
			chk(ea1, 24'h400012);
			acc(24'h400014, 1, 0, 0);
			chk(t1 - t, k != 0);
		end
		for (int k = 0; k < 2; k++) begin
			rw(5'h00, 32'h404 | (k << 4));
			acc(24'h200000, 0, 0, 0);
			for (int i = 0; i < 9; i++) begin
				acc(2 * i, 0, 1, 0);
				if (i == 0) t1 = t;
				else chk(t < t1, (i % (4 << k)) != 0);
				if (i == 1 && k == 0) tb = t;
				if (i == 1) chk(rd, 16'hA501);
			end
		end
		rw(5'h00, 32'h60C);
		acc(24'h200000, 0, 0, 0);
		acc(24'h000000, 0, 1, 0);
		acc(24'h000002, 0, 1, 0);
		chk(t - tb, 1);
		t2 = t;
		wait_hold <= 1;
		acc(24'h000004, 0, 1, 0);
		chk(t, t2);
		acc(24'h200000, 0, 0, 0);
		fork
			repeat (6) @(posedge core_clk);
		join
		fork
			begin
				repeat (6) @(posedge core_clk);
				wait_hold <= 0;
			end
		join_none
		acc(24'h000000, 0, 1, 0);
		chk(t > t1, 1);
		acc(24'h000002, 0, 0, 0);
		chk(t, t1);
		rw(5'h0C, 32'h08);
		for (int k = 0; k < 2; k++) begin
			for (int d = 0; d < 2; d++) begin
				rw(5'h00, 32'h500 | (k << 6));
				acc(24'h200000, 0, 0, 0);
				acc(24'h600000, 0, 0, d);
				t1 = t;
				if (d == 1) chk(ta, 2 + k);
				acc(24'h600002, 0, 0, d);
				chk(t < t1, !(k == 0 && d == 1));
				if (k + d == 0) chk(t1, 5);
				if (k + d == 0) tdr = t1;
				if (k + d == 0) tpg = t;
			end
		end
		rw(5'h00, 32'h503);
		acc(24'h200000, 0, 0, 0);
		acc(24'h600000, 0, 0, 0);
		chk(t, tdr);
		rw(5'h00, 32'h583);
		acc(24'h200000, 0, 0, 0);
		chk(chip_select_n[3], 1'b0);
		acc(24'h600002, 0, 0, 0);
		chk(t, tpg + 1);
		chk(cs1, 8'hF7);
		chk(st1, 7'h7E);
		rw(5'h00, 32'h420);
		int_req <= 1;
		acc(24'h200000, 1, 0, 0);
		chk(gm[2:1], 2'b10);
		rw(5'h00, 32'h400);
		acc(24'h200002, 1, 0, 0);
		chk(gm[2:1], 2'b00);
		int_req <= 0;
		finish_test();
	end
endmodule
